// File: logic/service_io.v
// Functional notes
// - temperature register reads eight supply ok bits
// - power register reads eight supply ok bits
// - offsets end in 3 or 0 by lane
// - lamp bits 7,6 drive green/red error LEDs
// - lamp bits 2..0 modem, shutdown, start lamps
// - disk id register: channel 6..4, id 3..0
// - disk led: address 5..4, strobe 3, data 0
// - two activity registers drive sixteen LEDs
// - converter read returns eight-bit result
// - converter write loads five-bit channel select
// - fan registers take six-bit speed code
// - speed code zero or all ones: full
// - second fan register at its own address
// - alarm bits 1,0 fan tacho errors
// - four display addresses pass through
// - display selects, reset low; enable high
// - contrast bits: select, up/down, step strobe
// - decode 128k byte nv window, 16 clock regs
// - nv window start to end inclusive
// - debug switch or device asserts debug request
// - byte-wide transfers on data lines 7..0
`timescale 1ns/10ps
`include "service_io_regs.vh"
module service_io #(
    parameter E_CYCLES = `DISP_E_CYCLES  // display strobe width
) (
    input  wire        CLOCK,          // 20 MHz clock
    input  wire        RST_N,          // async reset, active low
    input  wire        LANE_ORDER,     // byte_lane_order_select
    input  wire [19:0] ADDR,           // host byte offset
    input  wire        SEL,            // access strobe, one cycle
    input  wire        WRITE,          // 1 write, 0 read
    input  wire [7:0]  WDATA,          // host write data
    output reg  [7:0]  RDATA,          // host read data
    output reg         ACK,            // access done pulse
    output reg         PAR,            // parity of read byte
    input  wire [7:0]  TEMP_OK,        // supply temperature ok pins
    input  wire [7:0]  POWER_OK,       // supply power ok pins
    output reg         ERR_GREEN,      // green error LED
    output reg         ERR_RED,        // red error LED
    output reg         MODEM_LAMP,     // modem_lamp
    output reg         SHUTDOWN_LAMP,  // shutdown_lamp
    output reg         START_LAMP,     // start_lamp
    output reg  [2:0]  SCSI_CHANNEL,   // scsi channel number
    output reg  [3:0]  SCSI_ID,        // scsi id
    output reg  [1:0]  DISK_LED_ADDR,  // disk led address
    output reg         DISK_LED_STB,   // disk led strobe
    output reg         DISK_LED_DATA,  // disk led data
    output reg  [15:0] ACTIVITY_LED,   // activity_led_output
    input  wire [7:0]  CONV0_RESULT,   // converter_result 0
    input  wire [7:0]  CONV1_RESULT,   // converter_result 1
    output reg  [4:0]  CONV0_CHAN,     // converter_channel_select 0
    output reg  [4:0]  CONV1_CHAN,     // converter_channel_select 1
    output reg         FAN0_PWM,       // fan speed output 0
    output reg         FAN1_PWM,       // fan speed output 1
    input  wire        UPS_OFFLINE,    // ups off line
    input  wire        UPS_UNCONN,     // ups not connected
    input  wire        EXT_ALARM,      // external alarm
    input  wire        ALARM_UNCONN,   // alarm not connected
    input  wire [1:0]  TACHO_ERR,      // fan tacho errors
    output reg         CONTRAST_SEL,   // contrast select
    output reg         CONTRAST_UP,    // contrast up/down
    output reg         CONTRAST_STEP,  // contrast step strobe
    output reg         DISP_H1_SEL_N,  // display_half1_select_n
    output reg         DISP_H2_SEL_N,  // display_half2_select_n
    output reg         DISP_RESET_N,   // display reset, low
    output reg         DISP_RW,        // display 1 read, 0 write
    output reg         DISP_DI,        // display 1 data, 0 instr
    output reg         DISP_E,         // display enable, high
    output reg  [7:0]  DISP_DOUT,      // display data out
    output reg         DISP_DOE_N,     // display data enable, low
    input  wire [7:0]  DISP_DIN,       // display data in
    output reg         NV_SEL,         // nv memory access pulse
    output reg  [16:0] NV_ADDR,        // nv byte address
    output reg         NV_RTC,         // access hits clock regs
    output reg         NV_WRITE,       // nv write
    output reg  [7:0]  NV_WDATA,       // nv write data
    input  wire [7:0]  NV_RDATA,       // nv read data, same cycle
    input  wire        DEBUG_SWITCH,   // front panel switch
    input  wire        DEBUG_SELF,     // device's own request
    output reg         DEBUG_REQ,      // debug request to host
    input  wire        DEBUG_IRQ_IN,   // debug interrupt from host
    output reg         DEBUG_IRQ       // debug interrupt, synced
);
    // synchronisers for pin inputs
    reg  [7:0]  temp_s1, temp_s2;       // temperature sync
    reg  [7:0]  pow_s1, pow_s2;         // power sync
    reg  [7:0]  c0_s1, c0_s2;           // converter 0 sync
    reg  [7:0]  c1_s1, c1_s2;           // converter 1 sync
    reg  [5:0]  al_s1, al_s2;           // alarm inputs sync
    reg  [2:0]  dbg_s1, dbg_s2;         // debug sync
    reg  [7:0]  disp_s1, disp_s2;       // display read sync
    reg  [5:0]  fan0_code, fan1_code;   // fan speed codes
    reg  [5:0]  pwm_cnt;                // shared pwm counter
    reg  [1:0]  disp_state;             // display cycle state
    reg  [3:0]  e_cnt;                  // enable width counter
    reg  [19:0] base;                   // offset in low-lane form
    reg         hit;                    // offset is lane-correct
    reg  [7:0]  rd;                     // read mux
    reg         disp_hit;               // display address decoded
    reg         nv_hit;                 // nv window decoded
    wire        busy;                   // display cycle in progress

    localparam D_IDLE = 2'b01;          // no display cycle
    localparam D_STRB = 2'b10;          // enable high

    // full speed for code zero or all ones, else duty of code
    function pwm_level;
        input [5:0] code;
        input [5:0] cnt;
        begin
            if (code == 6'h00 || code == 6'h3F)
                pwm_level = 1'b1;
            else
                pwm_level = (cnt < code);
        end
    endfunction

    // a display cycle blocks every other access until its strobe ends,
    // so no register or nv access can slip in under the slow display
    assign busy = (disp_state == D_STRB);

    // lane check and decode of the host offset
    always @* begin
        base = ADDR;
        hit  = 1'b0;
        if (LANE_ORDER) begin
            hit  = (ADDR[1:0] == 2'b11);
            base = {ADDR[19:2], 2'b00};
        end else begin
            hit  = (ADDR[1:0] == 2'b00);
        end
        nv_hit = hit && base >= `OFS_NV_START
                 && base <= `OFS_NV_END;
        disp_hit = hit && (base == `OFS_DISP_H1_DATA
                 || base == `OFS_DISP_H1_INSTR
                 || base == `OFS_DISP_H2_DATA
                 || base == `OFS_DISP_H2_INSTR);
    end

    // read multiplexer, unmapped reads give zero
    always @* begin
        rd = 8'h00;
        if (hit) begin
            case (base)
                `OFS_TEMP_OK:  rd = temp_s2;
                `OFS_POWER_OK: rd = pow_s2;
                `OFS_CONV0:    rd = c0_s2;
                `OFS_CONV1:    rd = c1_s2;
                `OFS_ALARM:    rd = {al_s2[5:2], 2'b00,
                                     al_s2[1:0]};
                default:       rd = 8'h00;
            endcase
        end
    end

    // two-flop synchronisers
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            temp_s1 <= 8'h00; temp_s2 <= 8'h00;
            pow_s1  <= 8'h00; pow_s2  <= 8'h00;
            c0_s1   <= 8'h00; c0_s2   <= 8'h00;
            c1_s1   <= 8'h00; c1_s2   <= 8'h00;
            al_s1   <= 6'h00; al_s2   <= 6'h00;
            dbg_s1  <= 3'h0;  dbg_s2  <= 3'h0;
            disp_s1 <= 8'h00; disp_s2 <= 8'h00;
        end else begin
            temp_s1 <= TEMP_OK;      temp_s2 <= temp_s1;
            pow_s1  <= POWER_OK;     pow_s2  <= pow_s1;
            c0_s1   <= CONV0_RESULT; c0_s2   <= c0_s1;
            c1_s1   <= CONV1_RESULT; c1_s2   <= c1_s1;
            al_s1   <= {UPS_OFFLINE, UPS_UNCONN, EXT_ALARM,
                        ALARM_UNCONN, TACHO_ERR};
            al_s2   <= al_s1;
            dbg_s1  <= {DEBUG_IRQ_IN, DEBUG_SELF, DEBUG_SWITCH};
            dbg_s2  <= dbg_s1;
            disp_s1 <= DISP_DIN;     disp_s2 <= disp_s1;
        end
    end

    // write-only registers hold last written value
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            {ERR_GREEN, ERR_RED} <= 2'b00;
            {MODEM_LAMP, SHUTDOWN_LAMP, START_LAMP} <= 3'b000;
            SCSI_CHANNEL  <= 3'h0;
            SCSI_ID       <= 4'h0;
            DISK_LED_ADDR <= 2'h0;
            DISK_LED_STB  <= 1'b0;
            DISK_LED_DATA <= 1'b0;
            ACTIVITY_LED  <= 16'h0000;
            CONV0_CHAN    <= 5'h00;
            CONV1_CHAN    <= 5'h00;
            fan0_code     <= 6'h00;
            fan1_code     <= 6'h00;
            CONTRAST_SEL  <= 1'b0;
            CONTRAST_UP   <= 1'b0;
            CONTRAST_STEP <= 1'b0;
        end else if (SEL && WRITE && hit && !busy) begin
            case (base)
                `OFS_LAMP: begin
                    ERR_GREEN     <= WDATA[7];
                    ERR_RED       <= WDATA[6];
                    MODEM_LAMP    <= WDATA[2];
                    SHUTDOWN_LAMP <= WDATA[1];
                    START_LAMP    <= WDATA[0];
                end
                `OFS_DISK_ID: begin
                    SCSI_CHANNEL <= WDATA[6:4];
                    SCSI_ID      <= WDATA[3:0];
                end
                `OFS_DISK_LED: begin
                    DISK_LED_ADDR <= WDATA[5:4];
                    DISK_LED_STB  <= WDATA[3];
                    DISK_LED_DATA <= WDATA[0];
                end
                `OFS_ACT_LOW:  ACTIVITY_LED[7:0]  <= WDATA;
                `OFS_ACT_HIGH: ACTIVITY_LED[15:8] <= WDATA;
                `OFS_CONV0:    CONV0_CHAN <= WDATA[4:0];
                `OFS_CONV1:    CONV1_CHAN <= WDATA[4:0];
                `OFS_FAN0:     fan0_code  <= WDATA[5:0];
                `OFS_FAN1:     fan1_code  <= WDATA[5:0];
                `OFS_CONTRAST: begin
                    CONTRAST_SEL  <= WDATA[7];
                    CONTRAST_UP   <= WDATA[6];
                    CONTRAST_STEP <= WDATA[0];
                end
                default: ;
            endcase
        end
    end

    // fan pwm, period of 63 counts
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pwm_cnt  <= 6'h00;
            FAN0_PWM <= 1'b1;
            FAN1_PWM <= 1'b1;
        end else begin
            pwm_cnt  <= (pwm_cnt >= `FAN_PERIOD - 6'h01) ? 6'h00
                        : pwm_cnt + 6'h01;
            FAN0_PWM <= pwm_level(fan0_code, pwm_cnt);
            FAN1_PWM <= pwm_level(fan1_code, pwm_cnt);
        end
    end

    // host answer, nv pass-through, display bus cycle
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00; ACK <= 1'b0; PAR <= 1'b0;
            NV_SEL <= 1'b0; NV_ADDR <= 17'h00000; NV_RTC <= 1'b0;
            NV_WRITE <= 1'b0; NV_WDATA <= 8'h00;
            DISP_H1_SEL_N <= 1'b1; DISP_H2_SEL_N <= 1'b1;
            DISP_RESET_N <= 1'b0; DISP_RW <= 1'b1; DISP_DI <= 1'b0;
            DISP_E <= 1'b0; DISP_DOUT <= 8'h00; DISP_DOE_N <= 1'b1;
            disp_state <= D_IDLE; e_cnt <= 4'h0;
        end else begin
            ACK <= 1'b0;
            NV_SEL <= 1'b0;
            DISP_RESET_N <= 1'b1;
            case (disp_state)
                D_IDLE: begin
                    if (SEL && !busy && nv_hit) begin
                        NV_SEL   <= 1'b1;
                        NV_ADDR  <= base[18:2] - 17'h08000;
                        NV_RTC   <= (base[18:2] - 17'h08000) < 17'h10;
                        NV_WRITE <= WRITE;
                        NV_WDATA <= WDATA;
                    end
                    if (SEL && disp_hit) begin
                        DISP_H1_SEL_N <= base[8];
                        DISP_H2_SEL_N <= ~base[8];
                        DISP_DI   <= ~base[7];
                        DISP_RW   <= ~WRITE;
                        DISP_DOUT <= WDATA;
                        DISP_DOE_N <= ~WRITE;
                        DISP_E    <= 1'b1;
                        e_cnt     <= E_CYCLES[3:0];
                        disp_state <= D_STRB;
                    end else if (SEL) begin
                        ACK   <= 1'b1;
                        RDATA <= nv_hit ? 8'h00 : rd;
                        PAR   <= ^rd;
                    end
                    // nv data lands a cycle after ACK: the chip answers
                    // from NV_ADDR, which is only valid once NV_SEL is up
                    if (NV_SEL) begin
                        RDATA <= NV_WRITE ? 8'h00 : NV_RDATA;
                        PAR   <= NV_WRITE ? 1'b0 : ^NV_RDATA;
                    end
                end
                D_STRB: begin
                    if (e_cnt > 4'h1) begin
                        e_cnt <= e_cnt - 4'h1;
                    end else begin
                        DISP_E <= 1'b0;
                        DISP_H1_SEL_N <= 1'b1;
                        DISP_H2_SEL_N <= 1'b1;
                        DISP_DOE_N <= 1'b1;
                        ACK   <= 1'b1;
                        RDATA <= DISP_RW ? disp_s2 : 8'h00;
                        PAR   <= DISP_RW ? ^disp_s2 : 1'b0;
                        disp_state <= D_IDLE;
                    end
                end
                default: disp_state <= D_IDLE;
            endcase
        end
    end

    // debug request out and host interrupt in
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            DEBUG_REQ <= 1'b0;
            DEBUG_IRQ <= 1'b0;
        end else begin
            DEBUG_REQ <= dbg_s2[0] | dbg_s2[1];
            DEBUG_IRQ <= dbg_s2[2];
        end
    end
endmodule // service_io

// File: logic/service_io_regs.vh
`ifndef SERVICE_IO_REGS_VH
`define SERVICE_IO_REGS_VH
// register offsets with the byte-lane order select at 0
`define OFS_TEMP_OK        20'h00380
`define OFS_POWER_OK       20'h00400
`define OFS_LAMP           20'h00480
`define OFS_DISK_ID        20'h00500
`define OFS_DISK_LED       20'h00580
`define OFS_ACT_LOW        20'h00600
`define OFS_ACT_HIGH       20'h00680
`define OFS_CONV0          20'h00700
`define OFS_CONV1          20'h00780
`define OFS_FAN0           20'h00800
`define OFS_FAN1           20'h00880
`define OFS_ALARM          20'h00900
`define OFS_CONTRAST       20'h00980
`define OFS_DISP_H1_DATA   20'h00A00
`define OFS_DISP_H1_INSTR  20'h00A80
`define OFS_DISP_H2_DATA   20'h00B00
`define OFS_DISP_H2_INSTR  20'h00B80
// non-volatile window, lane order select at 0
`define OFS_NV_START       20'h20000
`define OFS_NV_END         20'h9FFFC
// offset added in high lane order
`define OFS_LANE_HIGH      20'h00003
// reset value of write-only registers
`define RST_WRITE_REG      8'h00
// display strobe width in cycles (time in ns, clock period in ns)
`define DISP_E_NS          450
`define CLK_NS             50
`define DISP_E_CYCLES      ((`DISP_E_NS + `CLK_NS - 1) / `CLK_NS)
// fan pwm period in cycles
`define FAN_PERIOD         6'h3F
`endif

// File: verif/service_io_sva.sv
`timescale 1ns/10ps
`include "service_io_regs.vh"
module service_io_sva #(
    parameter E_CYCLES = `DISP_E_CYCLES  // display strobe width
) (
    input logic        CLOCK,          // clock
    input logic        RST_N,          // reset, low
    input logic        LANE_ORDER,     // lane order
    input logic [19:0] ADDR,           // offset
    input logic        SEL,            // request
    input logic        WRITE,          // direction
    input logic [7:0]  WDATA,          // write data
    input logic [7:0]  RDATA,          // read data
    input logic        ACK,            // answer
    input logic        PAR,            // parity
    input logic        ERR_GREEN,      // lamp
    input logic        ERR_RED,        // lamp
    input logic        MODEM_LAMP,     // lamp
    input logic        SHUTDOWN_LAMP,  // lamp
    input logic        START_LAMP,     // lamp
    input logic        FAN0_PWM,       // fan output
    input logic        DISP_E,         // display strobe
    input logic        DISP_H1_SEL_N,  // half 1 select
    input logic        DISP_H2_SEL_N,  // half 2 select
    input logic        DISP_DOE_N,     // display data drive, low
    input logic        DISP_DI,        // data or instruction
    input logic        DISP_RW,        // read or write
    input logic        NV_SEL,         // nv access
    input logic [16:0] NV_ADDR,        // nv address
    input logic        NV_WRITE,       // nv direction
    input logic [7:0]  NV_WDATA,       // nv write data
    input logic        NV_RTC,         // clock region
    input logic        DEBUG_SWITCH,   // panel switch
    input logic        DEBUG_SELF,     // own request
    input logic        DEBUG_REQ       // request out
);
    // request decode as the device should see it
    wire [19:0] lo = LANE_ORDER ? `OFS_LANE_HIGH : 20'h0;
    wire        take = SEL && !DISP_E;
    wire        wr_lamp = take && WRITE && ADDR == (`OFS_LAMP | lo);
    wire        wr_fan = take && WRITE && ADDR == (`OFS_FAN0 | lo);
    wire        wr_disp = take && WRITE && ADDR == (`OFS_DISP_H1_DATA | lo);
    wire        disp_acc = take && ADDR[19:9] == 11'h005
                           && ADDR[6:0] == lo[6:0];
    wire        nv_hit = take && ADDR >= `OFS_NV_START
                         && ADDR <= (`OFS_NV_END | lo);
    wire [19:0] nv_off = (ADDR - `OFS_NV_START) >> 2;
    wire [4:0]  lamp_in = {WDATA[7:6], WDATA[2:0]};
    wire [4:0]  lamp_out = {ERR_GREEN, ERR_RED, MODEM_LAMP, SHUTDOWN_LAMP,
                            START_LAMP};
    wire        dbg_any = DEBUG_SWITCH || DEBUG_SELF;
    logic [1:0] since;                 // cycles since reset, saturating
    logic [4:0] e_cnt;                 // strobe high cycles
    // helper counters
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            since <= 2'd0;
            e_cnt <= 5'd0;
        end else begin
            since <= (since == 2'd3) ? since : since + 2'd1;
            e_cnt <= DISP_E ? e_cnt + 5'd1 : 5'd0;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence s_h1_strobe; DISP_E && !DISP_H1_SEL_N && DISP_DI && !DISP_RW;
    endsequence
    sequence s_strobe_done; !DISP_E && ACK; endsequence
    property p_ack_once; ACK |=> !ACK; endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("answer longer than one cycle");
    property p_parity; ACK && !$past(nv_hit) |-> PAR == ^RDATA; endproperty
    a_parity: assert property (p_parity)
        else $error("parity does not match read byte");
    property p_lamp; wr_lamp |=> lamp_out == $past(lamp_in); endproperty
    a_lamp: assert property (p_lamp)
        else $error("lamp outputs differ from written bits");
    property p_hold; !wr_lamp |=> $stable(lamp_out); endproperty
    a_hold: assert property (p_hold)
        else $error("lamp outputs moved without a write");
    property p_fan_full;
        wr_fan && (WDATA[5:0] == 6'h00 || WDATA[5:0] == 6'h3F)
            |-> ##2 FAN0_PWM [*8];
    endproperty
    a_fan_full: assert property (p_fan_full)
        else $error("fan not at full speed");
    property p_disp; wr_disp |=> s_h1_strobe ##[1:20] s_strobe_done;
    endproperty
    a_disp: assert property (p_disp)
        else $error("display write cycle malformed");
    property p_disp_pins;
        disp_acc |=> DISP_E && DISP_H1_SEL_N == $past(ADDR[8])
            && DISP_H2_SEL_N != $past(ADDR[8]) && DISP_DI != $past(ADDR[7])
            && DISP_RW != $past(WRITE) && DISP_DOE_N != $past(WRITE);
    endproperty
    a_disp_pins: assert property (p_disp_pins)
        else $error("display select or direction lines wrong");
    property p_e_width; $fell(DISP_E) |-> e_cnt == E_CYCLES; endproperty
    a_e_width: assert property (p_e_width)
        else $error("display strobe width wrong");
    property p_nv;
        NV_SEL |-> $past(nv_hit) && {3'b0, NV_ADDR} == $past(nv_off)
                   && NV_RTC == (NV_ADDR < 17'd16)
                   && NV_WRITE == $past(WRITE) && NV_WDATA == $past(WDATA);
    endproperty
    a_nv: assert property (p_nv)
        else $error("nv access address wrong");
    property p_debug; since == 2'd3 |-> DEBUG_REQ == $past(dbg_any, 3);
    endproperty
    a_debug: assert property (p_debug)
        else $error("debug request not the or of its sources");
endmodule // service_io_sva
bind service_io service_io_sva #(.E_CYCLES(E_CYCLES)) chk (.*);

// File: verif/host_model.sv
`timescale 1ns/10ps
`include "service_io_regs.vh"
module host_model (
    input  logic        CLOCK,         // bus clock
    input  logic        ACK,           // access done
    input  logic        DEBUG_REQ,     // debug request from device
    output logic        LANE_ORDER,    // host lane order setting
    output logic        SEL,           // request strobe
    output logic        WRITE,         // 1 write
    output logic [19:0] ADDR,          // byte offset
    output logic [7:0]  WDATA,         // write data
    output logic        DEBUG_IRQ_IN   // debug interrupt to device
);
    initial begin
        {LANE_ORDER, SEL, WRITE, ADDR, WDATA, DEBUG_IRQ_IN} = '0;
    end
    // answer a debug request with the interrupt line
    always @(posedge CLOCK) DEBUG_IRQ_IN <= DEBUG_REQ;
    // one byte access: one-cycle strobe, then wait for the answer
    task automatic access(input logic wr, input logic [19:0] ofs,
                          input logic [7:0] dt, output logic ok);
        int n;
        SEL <= 1'b1;
        WRITE <= wr;
        ADDR <= ofs | (LANE_ORDER ? `OFS_LANE_HIGH : 20'h0);
        WDATA <= dt;
        @(posedge CLOCK);
        SEL <= 1'b0;
        for (n = 0; n < 40 && ACK !== 1'b1; n++) @(posedge CLOCK);
        ok = (n < 40);
    endtask
endmodule // host_model

// File: verif/service_io_tb.sv
`timescale 1ns/10ps
`include "service_io_regs.vh"
module service_io_tb;
    logic        CLOCK, RST_N, LANE_ORDER, SEL, WRITE, ACK, PAR, FAN0_PWM;
    logic        ERR_GREEN, ERR_RED, MODEM_LAMP, SHUTDOWN_LAMP, START_LAMP;
    logic        DISK_LED_STB, DISK_LED_DATA, FAN1_PWM, DISP_E, DISP_DI;
    logic        CONTRAST_SEL, CONTRAST_UP, CONTRAST_STEP, DISP_RW, DISP_DOE_N;
    logic        DISP_H1_SEL_N, DISP_H2_SEL_N, DISP_RESET_N, NV_SEL, NV_RTC;
    logic        NV_WRITE, DEBUG_SWITCH, DEBUG_SELF, DEBUG_REQ, DEBUG_IRQ_IN;
    logic        DEBUG_IRQ, UPS_OFFLINE, UPS_UNCONN, EXT_ALARM, ALARM_UNCONN;
    logic [1:0]  TACHO_ERR, DISK_LED_ADDR;
    logic [2:0]  SCSI_CHANNEL;
    logic [3:0]  SCSI_ID;
    logic [4:0]  CONV0_CHAN, CONV1_CHAN;
    logic [7:0]  WDATA, RDATA, TEMP_OK, POWER_OK, CONV0_RESULT, CONV1_RESULT;
    logic [7:0]  DISP_DIN, DISP_DOUT, NV_RDATA, NV_WDATA, d;
    logic [15:0] ACTIVITY_LED;
    logic [16:0] NV_ADDR;
    logic [19:0] ADDR;
    logic [8:0]  expq[$];  // expected reads, bit 8 marks late data
    logic [7:0]  wd[8];    // last data written per register
    int          n_fail, check_count, c0, c1;
    logic [19:0] wofs[8] = '{`OFS_LAMP, `OFS_DISK_ID, `OFS_DISK_LED,
        `OFS_ACT_LOW, `OFS_ACT_HIGH, `OFS_CONV0, `OFS_CONV1, `OFS_CONTRAST};
    logic [19:0] nofs[4] = '{`OFS_NV_START, 20'h2003C, 20'h20040, `OFS_NV_END};
    logic [19:0] dofs[4] = '{`OFS_DISP_H1_DATA, `OFS_DISP_H1_INSTR,
        `OFS_DISP_H2_DATA, `OFS_DISP_H2_INSTR};

    service_io #(.E_CYCLES(2)) uut (.*);
    host_model hm (.*);
    // nv chip answers in the same cycle from its address
    assign NV_RDATA = NV_ADDR[7:0] ^ 8'hA5;
    initial begin CLOCK = 0; forever #25 CLOCK = ~CLOCK; end

    task note(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_read(input logic [8:0] got, input logic [8:0] exp);
        note(64'(got), 64'(exp));
    endtask
    task cmp_pins(input logic [63:0] got, input logic [63:0] exp);
        note(got, exp);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one access, its expected read noted first
    task xfer(input logic wr, input logic [19:0] o, input logic [7:0] dt,
              input logic [8:0] e);
        logic ok;
        expq.push_back(e);
        hm.access(wr, o, dt, ok);
        cmp_pins(64'(ok), 64'h1);
    endtask
    function logic [8:0] nv_want(input logic [19:0] o);
        logic [19:0] a;
        a = (o - `OFS_NV_START) >> 2;
        return {1'b1, a[7:0] ^ 8'hA5};
    endfunction
    task count_fans;
        c0 = 0;
        c1 = 0;
        repeat (3) @(posedge CLOCK);
        repeat (126) begin
            @(posedge CLOCK);
            c0 += FAN0_PWM;
            c1 += FAN1_PWM;
        end
    endtask
    // each answer takes the oldest expectation off the queue
    always @(posedge CLOCK) begin : mon
        logic [8:0] e;
        if (ACK === 1'b1) begin
            e = expq.size() ? expq.pop_front() : 9'h1FF;
            if (e[8]) @(posedge CLOCK);
            cmp_read({!e[8] & PAR, RDATA},
                     {!e[8] & ^e[7:0], e[7:0]});
        end
    end
    // watchdog
    initial begin
        #1000000;
        n_fail++;
        give_verdict;
    end
    initial begin
        void'($urandom(8856));
        RST_N = 0;
        {DEBUG_SWITCH, DEBUG_SELF, DISP_DIN} = '0;
        {TEMP_OK, POWER_OK, CONV0_RESULT, CONV1_RESULT} = '0;
        {UPS_OFFLINE, UPS_UNCONN, EXT_ALARM, ALARM_UNCONN, TACHO_ERR} = '0;
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        for (int ln = 0; ln < 2; ln++) begin
            hm.LANE_ORDER <= ln[0];
            {TEMP_OK, POWER_OK, CONV0_RESULT, CONV1_RESULT} <= $urandom;
            {UPS_OFFLINE, UPS_UNCONN, EXT_ALARM, ALARM_UNCONN, TACHO_ERR}
                <= 6'($urandom);
            repeat (4) @(posedge CLOCK);
            xfer(0, `OFS_TEMP_OK, 0, {1'b0, TEMP_OK});
            xfer(0, `OFS_POWER_OK, 0, {1'b0, POWER_OK});
            xfer(0, `OFS_CONV0, 0, {1'b0, CONV0_RESULT});
            xfer(0, `OFS_CONV1, 0, {1'b0, CONV1_RESULT});
            xfer(0, `OFS_ALARM, 0, {1'b0, UPS_OFFLINE, UPS_UNCONN, EXT_ALARM,
                 ALARM_UNCONN, 2'b00, TACHO_ERR});
            xfer(0, `OFS_LAMP, 0, 9'h0);
            xfer(0, 20'h00381, 0, ln ? {1'b0, TEMP_OK} : 9'h0);
            $display("status reads done, lane %0d", ln);
            xfer(1, `OFS_DISK_LED, 8'h31, 9'h0);
            xfer(1, `OFS_DISK_LED, 8'h39, 9'h0);
            foreach (wd[i]) begin
                wd[i] = $urandom;
                xfer(1, wofs[i], wd[i],
                     i == 5 ? {1'b0, CONV0_RESULT} :
                     i == 6 ? {1'b0, CONV1_RESULT} : 9'h0);
            end
            cmp_pins({ERR_GREEN, ERR_RED, MODEM_LAMP,
                SHUTDOWN_LAMP, START_LAMP, SCSI_CHANNEL, SCSI_ID,
                DISK_LED_ADDR, DISK_LED_STB, DISK_LED_DATA,
                ACTIVITY_LED, CONV0_CHAN, CONV1_CHAN,
                CONTRAST_SEL, CONTRAST_UP, CONTRAST_STEP},
                {wd[0][7:6], wd[0][2:0], wd[1][6:0], wd[2][5:3], wd[2][0],
                wd[4], wd[3], wd[5][4:0], wd[6][4:0], wd[7][7:6], wd[7][0]});
            $display("register writes done, lane %0d", ln);
            foreach (nofs[i])
                xfer(0, nofs[i], 0, nv_want(nofs[i]));
            xfer(1, 20'h20040, 8'h5A, 9'h0);
            xfer(0, 20'h1FFFC, 0, 9'h0);
            $display("nv window done, lane %0d", ln);
        end
        xfer(1, `OFS_FAN0, 8'hFF, 9'h0);
        xfer(1, `OFS_FAN1, 8'hC0, 9'h0);
        count_fans;
        cmp_pins({c0, c1}, {32'd126, 32'd126});
        xfer(1, `OFS_FAN1, 8'h20, 9'h0);
        count_fans;
        cmp_pins({c0, 31'd0, c1 > 0 && c1 < 126}, {32'd126, 32'd1});
        $display("fan speeds done");
        foreach (dofs[i]) begin
            d = $urandom;
            xfer(1, dofs[i], d, 9'h0);
            cmp_pins(DISP_DOUT, d);
            DISP_DIN <= d;
            xfer(0, dofs[i], 0, {1'b0, d});
            cmp_pins({DISP_E, DISP_RESET_N}, 64'h1);
        end
        $display("display cycles done");
        for (int k = 2; k >= 0; k--) begin
            {DEBUG_SWITCH, DEBUG_SELF} <= 2'(k);
            repeat (8) @(posedge CLOCK);
            cmp_pins({DEBUG_REQ, DEBUG_IRQ}, {2{k != 0}});
        end
        $display("debug request done");
        give_verdict;
    end
endmodule // service_io_tb
